// ==== hdl/status_event_pkg.sv ====
// Purpose: shared constants for the status event group logic
// Assumes: 16-bit status groups, register selects coined locally
// Notes:   no software bus; registers are reached through a command port
package status_event_pkg;
	localparam int unsigned GROUP_W = 16;

	// register select codes on the command port
	typedef enum logic [2:0] {
		SEL_COND   = 3'h0,
		SEL_EVENT  = 3'h1,
		SEL_ENABLE = 3'h2,
		SEL_FALL   = 3'h3,
		SEL_RISE   = 3'h4
	} reg_sel_t;

	localparam logic [GROUP_W-1:0] ENABLE_PRESET = 16'h0000;
	localparam logic [GROUP_W-1:0] FALL_PRESET   = 16'h0000;
	localparam logic [GROUP_W-1:0] RISE_PRESET   = 16'hFFFF;
	localparam logic [GROUP_W-1:0] ZERO_WORD     = 16'h0000;

	// status byte layout
	localparam int unsigned STB_W        = 8;
	localparam int unsigned STB_QUESTIONABLE_SUMMARY_BIT_BIT = 3;
	localparam int unsigned STB_MAV_BIT  = 4;
	localparam int unsigned STB_OPERATION_SUMMARY_BIT_BIT = 7;

	localparam int unsigned GROUP_OPERATION_SUMMARY_BIT = 0;
	localparam int unsigned GROUP_QUESTIONABLE_SUMMARY_BIT = 1;
endpackage

// ==== hdl/status_event_group_logic.sv ====
// Purpose: operation and questionable status groups with summary bits
// Assumes: one 100 MHz clock; status inputs may be asynchronous
// Notes:   commands arrive as one-cycle strobes from the command parser
//
// Summary of operation
// - each group summary is OR of event bits gated by enable mask
// - questionable summary bit comes from questionable events passed by enable
// - falling-edge mask bit set: falling condition sets event bit
// - rising-edge mask bit set: rising condition sets event bit
// - event bits latch, and only filtered transitions set them
// - reading an event register returns contents then clears them
// - instrument reset leaves event registers unchanged
// - condition register tracks live inputs, reading does not alter it
// - instrument reset clears questionable condition except still-present bits
// - preset clears enable and falling masks, sets rising masks, both groups
// - clear-status clears event registers, leaves enable masks alone
// - clear-status clears all event registers, status byte summary bits and error queue
// - clear-status after message terminator also empties output queue
// - values are binary-weighted sums, bit n weighs two to the n
`timescale 1ns/1ps
`default_nettype none
module status_event_group_logic (
	input  wire logic                  ref_clk_in,
	input  wire logic                  rst_n_in,
	input  wire logic [15:0]           operation_summary_bit_status_in,
	input  wire logic [15:0]           questionable_summary_bit_status_in,
	input  wire logic                  wr_strobe_in,
	input  wire logic                  rd_strobe_in,
	input  wire logic                  group_in,
	input  wire logic [2:0]            reg_sel_in,
	input  wire logic [15:0]           wr_data_in,
	input  wire logic                  preset_in,
	input  wire logic                  clear_status_in,
	input  wire logic                  instr_reset_in,
	input  wire logic                  after_terminator_in,
	input  wire logic                  message_available_in,
	output logic      [15:0]           rd_data_out,
	output logic                       rd_valid_out,
	output logic                       operation_summary_bit_out,
	output logic                       questionable_summary_bit_out,
	output logic      [7:0]            status_byte_out,
	output logic                       error_queue_clear_out,
	output logic                       output_queue_clear_out
);
	localparam int unsigned W = status_event_pkg::GROUP_W;

	logic          rst_meta;
	logic          rst_sync_n;
	logic [W-1:0]  sync1 [2];
	logic [W-1:0]  sync2 [2];
	logic [W-1:0]  sync3 [2];
	logic [W-1:0]  cond [2];
	logic [W-1:0]  cond_prev [2];
	logic [W-1:0]  event_reg [2];
	logic [W-1:0]  enable_mask [2];
	logic [W-1:0]  falling_edge_filter_mask [2];
	logic [W-1:0]  rising_edge_filter_mask [2];
	logic          mav_masked;
	logic [W-1:0]  rd_data;
	logic          rd_valid;
	logic          err_clr;
	logic          oq_clr;

	logic [W-1:0]  next_cond [2];
	logic [W-1:0]  next_event [2];
	logic [W-1:0]  next_enable [2];
	logic [W-1:0]  next_fall [2];
	logic [W-1:0]  next_rise [2];
	logic          next_mav_masked;
	logic [W-1:0]  next_rd_data;
	logic          next_rd_valid;
	logic          next_err_clr;
	logic          next_oq_clr;
	logic [W-1:0]  set_bits [2];

	function automatic logic [W-1:0] edge_events(input logic [W-1:0] now,
		input logic [W-1:0] prev, input logic [W-1:0] fall, input logic [W-1:0] rise);
		edge_events = (prev & ~now & fall) | (~prev & now & rise);
	endfunction

	function automatic logic summary(input logic [W-1:0] ev, input logic [W-1:0] en);
		summary = |(ev & en);
	endfunction

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// three-stage synchroniser; a change counts once stages two and three agree
	always_ff @(posedge ref_clk_in or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			for (int g = 0; g < 2; g++) begin
				sync1[g] <= status_event_pkg::ZERO_WORD;
				sync2[g] <= status_event_pkg::ZERO_WORD;
				sync3[g] <= status_event_pkg::ZERO_WORD;
			end
		end else begin
			sync1[status_event_pkg::GROUP_OPERATION_SUMMARY_BIT] <= operation_summary_bit_status_in;
			sync1[status_event_pkg::GROUP_QUESTIONABLE_SUMMARY_BIT] <= questionable_summary_bit_status_in;
			for (int g = 0; g < 2; g++) begin
				sync2[g] <= sync1[g];
				sync3[g] <= sync2[g];
			end
		end
	end

	always_comb begin
		next_mav_masked = mav_masked;
		next_rd_data    = rd_data;
		next_rd_valid   = 1'b0;
		next_err_clr    = clear_status_in;
		next_oq_clr     = clear_status_in && after_terminator_in;
		if (clear_status_in) begin
			next_mav_masked = after_terminator_in;
		end else if (!message_available_in) begin
			next_mav_masked = 1'b0;
		end
		for (int g = 0; g < 2; g++) begin
			// condition bits only move where stages agree, so no glitch is seen
			next_cond[g] = (sync2[g] & sync3[g]) | (cond[g] & (sync2[g] | sync3[g]));
			// reset drops only bits whose source is gone; live ones re-assert
			if (instr_reset_in && g == status_event_pkg::GROUP_QUESTIONABLE_SUMMARY_BIT) begin
				next_cond[g] = cond[g] & sync2[g] & sync3[g];
			end
			next_enable[g] = enable_mask[g];
			next_fall[g]   = falling_edge_filter_mask[g];
			next_rise[g]   = rising_edge_filter_mask[g];
			set_bits[g]    = edge_events(cond[g], cond_prev[g],
				falling_edge_filter_mask[g], rising_edge_filter_mask[g]);
			next_event[g]  = event_reg[g];
			if (clear_status_in) begin
				next_event[g] = status_event_pkg::ZERO_WORD;
			end
			if (rd_strobe_in && group_in == g[0] &&
				reg_sel_in == status_event_pkg::SEL_EVENT) begin
				next_event[g] = status_event_pkg::ZERO_WORD;
			end
			next_event[g] = next_event[g] | set_bits[g];
			if (wr_strobe_in && group_in == g[0]) begin
				unique case (reg_sel_in)
					status_event_pkg::SEL_ENABLE: next_enable[g] = wr_data_in;
					status_event_pkg::SEL_FALL:   next_fall[g]   = wr_data_in;
					status_event_pkg::SEL_RISE:   next_rise[g]   = wr_data_in;
					default: ; // condition and event are read-only
				endcase
			end
			if (preset_in) begin
				next_enable[g] = status_event_pkg::ENABLE_PRESET;
				next_fall[g]   = status_event_pkg::FALL_PRESET;
				next_rise[g]   = status_event_pkg::RISE_PRESET;
			end
		end
		if (rd_strobe_in) begin
			next_rd_valid = 1'b1;
			unique case (reg_sel_in)
				status_event_pkg::SEL_COND:   next_rd_data = cond[group_in];
				status_event_pkg::SEL_EVENT:  next_rd_data = event_reg[group_in];
				status_event_pkg::SEL_ENABLE: next_rd_data = enable_mask[group_in];
				status_event_pkg::SEL_FALL:   next_rd_data = falling_edge_filter_mask[group_in];
				status_event_pkg::SEL_RISE:   next_rd_data = rising_edge_filter_mask[group_in];
				default:                      next_rd_data = status_event_pkg::ZERO_WORD;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			for (int g = 0; g < 2; g++) begin
				cond[g]                     <= status_event_pkg::ZERO_WORD;
				cond_prev[g]                <= status_event_pkg::ZERO_WORD;
				event_reg[g]                <= status_event_pkg::ZERO_WORD;
				enable_mask[g]              <= status_event_pkg::ENABLE_PRESET;
				falling_edge_filter_mask[g] <= status_event_pkg::FALL_PRESET;
				rising_edge_filter_mask[g]  <= status_event_pkg::RISE_PRESET;
			end
			mav_masked <= 1'b0;
			rd_data    <= status_event_pkg::ZERO_WORD;
			rd_valid   <= 1'b0;
			err_clr    <= 1'b0;
			oq_clr     <= 1'b0;
		end else begin
			for (int g = 0; g < 2; g++) begin
				cond[g]                     <= next_cond[g];
				cond_prev[g]                <= cond[g];
				event_reg[g]                <= next_event[g];
				enable_mask[g]              <= next_enable[g];
				falling_edge_filter_mask[g] <= next_fall[g];
				rising_edge_filter_mask[g]  <= next_rise[g];
			end
			mav_masked <= next_mav_masked;
			rd_data    <= next_rd_data;
			rd_valid   <= next_rd_valid;
			err_clr    <= next_err_clr;
			oq_clr     <= next_oq_clr;
		end
	end

	// summaries are combinational so a cleared event drops its summary at once
	assign operation_summary_bit_out = summary(event_reg[status_event_pkg::GROUP_OPERATION_SUMMARY_BIT],
		enable_mask[status_event_pkg::GROUP_OPERATION_SUMMARY_BIT]);
	assign questionable_summary_bit_out = summary(event_reg[status_event_pkg::GROUP_QUESTIONABLE_SUMMARY_BIT],
		enable_mask[status_event_pkg::GROUP_QUESTIONABLE_SUMMARY_BIT]);

	always_comb begin
		status_byte_out = '0;
		status_byte_out[status_event_pkg::STB_OPERATION_SUMMARY_BIT_BIT] = operation_summary_bit_out;
		status_byte_out[status_event_pkg::STB_QUESTIONABLE_SUMMARY_BIT_BIT] = questionable_summary_bit_out;
		// message-available stays low after a terminated clear until the queue refills
		status_byte_out[status_event_pkg::STB_MAV_BIT] = message_available_in && !mav_masked;
	end

	assign rd_data_out            = rd_data;
	assign rd_valid_out           = rd_valid;
	assign error_queue_clear_out  = err_clr;
	assign output_queue_clear_out = oq_clr;

	property p_rise_sets;
		@(posedge ref_clk_in) disable iff (!rst_sync_n)
		(!cond_prev[1][0] && cond[1][0] && rising_edge_filter_mask[1][0]) |=> event_reg[1][0];
	endproperty
	a_rise_sets: assert property (p_rise_sets) else $error("rise lost");

	property p_fall_sets;
		@(posedge ref_clk_in) disable iff (!rst_sync_n)
		(cond_prev[0][1] && !cond[0][1] && falling_edge_filter_mask[0][1]) |=> event_reg[0][1];
	endproperty
	a_fall_sets: assert property (p_fall_sets) else $error("fall lost");

	property p_latch;
		@(posedge ref_clk_in) disable iff (!rst_sync_n)
		(event_reg[0][2] && !clear_status_in && !rd_strobe_in) |=> event_reg[0][2];
	endproperty
	a_latch: assert property (p_latch) else $error("event dropped");

	property p_no_spurious;
		@(posedge ref_clk_in) disable iff (!rst_sync_n)
		(!event_reg[1][3] && cond[1][3] == cond_prev[1][3]) |=> !event_reg[1][3];
	endproperty
	a_no_spurious: assert property (p_no_spurious) else $error("spurious event");

	property p_read_clears;
		@(posedge ref_clk_in) disable iff (!rst_sync_n)
		(rd_strobe_in && reg_sel_in == status_event_pkg::SEL_EVENT && set_bits[group_in] == '0)
		|=> event_reg[$past(group_in)] == '0 && rd_valid;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("read did not clear");

	property p_preset;
		@(posedge ref_clk_in) disable iff (!rst_sync_n)
		preset_in |=> rising_edge_filter_mask[1] == status_event_pkg::RISE_PRESET
			&& enable_mask[0] == '0 && falling_edge_filter_mask[1] == '0;
	endproperty
	a_preset: assert property (p_preset) else $error("preset wrong");

	property p_cls_keeps_enable;
		@(posedge ref_clk_in) disable iff (!rst_sync_n)
		(clear_status_in && !wr_strobe_in && !preset_in)
		|=> $stable(enable_mask[0]) && error_queue_clear_out;
	endproperty
	a_cls_keeps_enable: assert property (p_cls_keeps_enable) else $error("cls bad");

	property p_summary;
		@(posedge ref_clk_in) disable iff (!rst_sync_n)
		status_byte_out[status_event_pkg::STB_QUESTIONABLE_SUMMARY_BIT_BIT] == |(event_reg[1] & enable_mask[1]);
	endproperty
	a_summary: assert property (p_summary) else $error("summary wrong");

	// second step: the pulse drops unless a new terminated clear came right behind it
	sequence s_oq_pulse;
		output_queue_clear_out ##1
		(!output_queue_clear_out || $past(clear_status_in && after_terminator_in));
	endsequence

	property p_oq_clear;
		@(posedge ref_clk_in) disable iff (!rst_sync_n)
		(clear_status_in && after_terminator_in) |=> s_oq_pulse;
	endproperty
	a_oq_clear: assert property (p_oq_clear) else $error("oq clear missing");

	property p_cls_clears;
		@(posedge ref_clk_in) disable iff (!rst_sync_n)
		clear_status_in |=> (event_reg[0] & ~$past(set_bits[0])) == '0
			&& (event_reg[1] & ~$past(set_bits[1])) == '0;
	endproperty
	a_cls_clears: assert property (p_cls_clears) else $error("clear left events");

	property p_mav_cleared;
		@(posedge ref_clk_in) disable iff (!rst_sync_n)
		(clear_status_in && after_terminator_in)
		|=> !status_byte_out[status_event_pkg::STB_MAV_BIT];
	endproperty
	a_mav_cleared: assert property (p_mav_cleared) else $error("mav not cleared");

	property p_reset_keeps_events;
		@(posedge ref_clk_in) disable iff (!rst_sync_n)
		(instr_reset_in && !clear_status_in && !rd_strobe_in)
		|=> (event_reg[1] & $past(event_reg[1])) == $past(event_reg[1]);
	endproperty
	a_reset_keeps_events: assert property (p_reset_keeps_events) else $error("reset lost events");

	// agreeing stages must land in the condition register on the next edge
	property p_cond_tracks;
		@(posedge ref_clk_in) disable iff (!rst_sync_n)
		(sync2[0] == sync3[0]) |=> cond[0] == $past(sync3[0]);
	endproperty
	a_cond_tracks: assert property (p_cond_tracks) else $error("condition not tracking");

	property p_set_beats_read;
		@(posedge ref_clk_in) disable iff (!rst_sync_n)
		(rd_strobe_in && reg_sel_in == status_event_pkg::SEL_EVENT && set_bits[group_in] != '0)
		|=> (event_reg[$past(group_in)] & $past(set_bits[group_in])) == $past(set_bits[group_in]);
	endproperty
	a_set_beats_read: assert property (p_set_beats_read) else $error("event lost to read");
endmodule // status_event_group_logic
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the status event group logic
// Assumes: command strobes last one cycle; status pins settle well inside 8 cycles
// Notes:   one read/event collision is hand-timed at the end; pins move on rising edges
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		num_errors++; \
		$display("[FAIL] %s expected %h seen %h", nm, e, g); \
	end \
end
module testbench;
	typedef struct packed {logic grp; logic [2:0] sel; logic [15:0] exp;} row_t;
	logic        ref_clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [15:0] operation_summary_bit_status_in = 16'h0000;
	logic [15:0] questionable_summary_bit_status_in = 16'h0000;
	logic        wr_strobe_in = 1'b0;
	logic        rd_strobe_in = 1'b0;
	logic        group_in = 1'b0;
	logic [2:0]  reg_sel_in = 3'h0;
	logic [15:0] wr_data_in = 16'h0000;
	logic        preset_in = 1'b0;
	logic        clear_status_in = 1'b0;
	logic        instr_reset_in = 1'b0;
	logic        after_terminator_in = 1'b0;
	logic        message_available_in = 1'b0;
	logic [15:0] rd_data_out;
	logic        rd_valid_out;
	logic        operation_summary_bit_sum;
	logic        questionable_summary_bit_sum;
	logic [7:0]  status_byte_out;
	logic        err_clr;
	logic        out_clr;
	int          num_errors = 0;
	int          cmp_count = 0;
	row_t        rows[12];

	status_event_group_logic dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
		.operation_summary_bit_status_in(operation_summary_bit_status_in), .questionable_summary_bit_status_in(questionable_summary_bit_status_in),
		.wr_strobe_in(wr_strobe_in), .rd_strobe_in(rd_strobe_in), .group_in(group_in),
		.reg_sel_in(reg_sel_in), .wr_data_in(wr_data_in), .preset_in(preset_in),
		.clear_status_in(clear_status_in), .instr_reset_in(instr_reset_in),
		.after_terminator_in(after_terminator_in),
		.message_available_in(message_available_in), .rd_data_out(rd_data_out),
		.rd_valid_out(rd_valid_out), .operation_summary_bit_out(operation_summary_bit_sum),
		.questionable_summary_bit_out(questionable_summary_bit_sum), .status_byte_out(status_byte_out),
		.error_queue_clear_out(err_clr), .output_queue_clear_out(out_clr));

	always #5 ref_clk_in = ~ref_clk_in;

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
	endtask

	task automatic wr(input logic g, input logic [2:0] s, input logic [15:0] d);
		@(posedge ref_clk_in);
		wr_strobe_in <= 1'b1;
		group_in     <= g;
		reg_sel_in   <= s;
		wr_data_in   <= d;
		@(posedge ref_clk_in);
		wr_strobe_in <= 1'b0;
	endtask

	// read data and its valid pulse are both looked at in the answer cycle
	task automatic rd(input logic g, input logic [2:0] s, input logic [15:0] e);
		@(posedge ref_clk_in);
		rd_strobe_in <= 1'b1;
		group_in     <= g;
		reg_sel_in   <= s;
		@(posedge ref_clk_in);
		rd_strobe_in <= 1'b0;
		@(negedge ref_clk_in);
		`CHK("rd_valid_out,rd_data_out", {1'b1, e}, {rd_valid_out, rd_data_out})
	endtask

	// k bits: 0 preset, 1 clear status, 2 instrument reset
	task automatic cmd(input logic [2:0] k);
		@(posedge ref_clk_in);
		preset_in       <= k[0];
		clear_status_in <= k[1];
		instr_reset_in  <= k[2];
		@(posedge ref_clk_in);
		{instr_reset_in, clear_status_in, preset_in} <= 3'h0;
		@(negedge ref_clk_in);
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		#50000;
		num_errors++;
		stop_test();
	end

	initial begin
		for (int i = 0; i < 12; i++) begin
			rows[i].grp = i[0];
			rows[i].sel = 3'(i / 2);
			rows[i].exp = (i / 2 == 4) ? 16'hFFFF : 16'h0000;
		end
		repeat (2) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge ref_clk_in);
		foreach (rows[i]) rd(rows[i].grp, rows[i].sel, rows[i].exp);
		wr(1'b0, status_event_pkg::SEL_ENABLE, 16'h0018);
		wr(1'b1, status_event_pkg::SEL_ENABLE, 16'h0018);
		rd(1'b0, status_event_pkg::SEL_ENABLE, 16'h0018);
		rd(1'b1, status_event_pkg::SEL_ENABLE, 16'h0018);
		@(posedge ref_clk_in);
		operation_summary_bit_status_in <= 16'h0001;
		wait_cyc(8);
		`CHK("operation_summary_bit_out", 1'b0, operation_summary_bit_sum)
		@(posedge ref_clk_in);
		operation_summary_bit_status_in <= 16'h0009;
		questionable_summary_bit_status_in <= 16'h0010;
		wait_cyc(8);
		`CHK("operation_summary_bit_out", 1'b1, operation_summary_bit_sum)
		`CHK("questionable_summary_bit_out", 1'b1, questionable_summary_bit_sum)
		`CHK("status_byte_out", 8'h88, status_byte_out)
		rd(1'b0, status_event_pkg::SEL_COND, 16'h0009);
		rd(1'b0, status_event_pkg::SEL_COND, 16'h0009);
		@(posedge ref_clk_in);
		operation_summary_bit_status_in <= 16'h0000;
		wait_cyc(8);
		rd(1'b0, status_event_pkg::SEL_COND, 16'h0000);
		rd(1'b0, status_event_pkg::SEL_EVENT, 16'h0009);
		rd(1'b0, status_event_pkg::SEL_EVENT, 16'h0000);
		`CHK("operation_summary_bit_out", 1'b0, operation_summary_bit_sum)
		wr(1'b0, status_event_pkg::SEL_RISE, 16'h0000);
		wr(1'b0, status_event_pkg::SEL_FALL, 16'h0001);
		@(posedge ref_clk_in);
		operation_summary_bit_status_in <= 16'h0001;
		wait_cyc(8);
		rd(1'b0, status_event_pkg::SEL_EVENT, 16'h0000);
		@(posedge ref_clk_in);
		operation_summary_bit_status_in <= 16'h0000;
		wait_cyc(8);
		rd(1'b0, status_event_pkg::SEL_EVENT, 16'h0001);
		wr(1'b0, status_event_pkg::SEL_RISE, 16'h0002);
		wr(1'b0, status_event_pkg::SEL_FALL, 16'h0000);
		@(posedge ref_clk_in);
		operation_summary_bit_status_in <= 16'h0002;
		wait_cyc(8);
		rd(1'b0, status_event_pkg::SEL_EVENT, 16'h0002);
		wr(1'b1, 3'h1, 16'hFFFF);
		rd(1'b1, 3'h5, 16'h0000);
		cmd(3'h4);
		wait_cyc(2);
		rd(1'b1, status_event_pkg::SEL_COND, 16'h0010);
		rd(1'b1, status_event_pkg::SEL_EVENT, 16'h0010);
		@(posedge ref_clk_in);
		questionable_summary_bit_status_in       <= 16'h0018;
		message_available_in <= 1'b1;
		after_terminator_in  <= 1'b1;
		wait_cyc(8);
		`CHK("status_byte_out", 8'h18, status_byte_out)
		cmd(3'h2);
		`CHK("error_queue_clear_out", 1'b1, err_clr)
		`CHK("output_queue_clear_out", 1'b1, out_clr)
		wait_cyc(1);
		`CHK("status_byte_out", 8'h00, status_byte_out)
		`CHK("error_queue_clear_out", 1'b0, err_clr)
		rd(1'b1, status_event_pkg::SEL_EVENT, 16'h0000);
		rd(1'b1, status_event_pkg::SEL_ENABLE, 16'h0018);
		@(posedge ref_clk_in);
		after_terminator_in  <= 1'b0;
		message_available_in <= 1'b0;
		wait_cyc(2);
		@(posedge ref_clk_in);
		message_available_in <= 1'b1;
		wait_cyc(2);
		cmd(3'h2);
		`CHK("error_queue_clear_out", 1'b1, err_clr)
		`CHK("output_queue_clear_out", 1'b0, out_clr)
		wait_cyc(1);
		`CHK("status_byte_out", 8'h10, status_byte_out)
		wr(1'b0, status_event_pkg::SEL_FALL, 16'h00F0);
		cmd(3'h1);
		foreach (rows[i]) if (rows[i].sel >= 3'h2) rd(rows[i].grp, rows[i].sel, rows[i].exp);
		// bit 2 rises so that its event lands on the very edge that takes the clearing read
		@(posedge ref_clk_in);
		operation_summary_bit_status_in <= 16'h0006;
		repeat (3) @(posedge ref_clk_in);
		rd(1'b0, status_event_pkg::SEL_EVENT, 16'h0000);
		rd(1'b0, status_event_pkg::SEL_EVENT, 16'h0004);
		stop_test();
	end
endmodule // testbench
`default_nettype wire
